// [hw/bus_reset_consts.svh]
// Constants for the bus reset and gap count control block.
// Behaviour
// - Start-reset write begins bus reset then initialisation.
// - Start-reset write loads hold-off and gap fields.
// - Sent or received config packets load both fields.
// - Two resets without update force gap 63.
// - Own register-started reset keeps written gap value.
`ifndef BUS_RESET_CONSTS_SVH
`define BUS_RESET_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define REG_IDX_RESET_GAP 1
`define REG_IDX_STATUS 2
`define REG_ADDR_RESET_GAP 8'h04
`define REG_ADDR_STATUS 8'h08

// Field positions inside the reset and gap control register.
`define FLD_HOLDOFF_BIT 7
`define FLD_START_BIT 6
`define FLD_GAP_MSB 5
`define FLD_GAP_LSB 0

// Field positions inside the status register.
`define FLD_ST_RESET_BIT 0
`define FLD_ST_INIT_BIT 1
`define FLD_ST_CNT_LSB 2
`define FLD_ST_CNT_MSB 3

// Reset values and the fall-back gap count.
`define GAP_MAX 6'h3F
`define GAP_RESET 6'h3F
`define HOLDOFF_RESET 1'b0
`define RESETS_TO_FALLBACK 2'h2

// Timing: bus reset signalling length, rounded up to whole cycles.
`define CLK_PERIOD_NS 20
`define BUS_RESET_TIME_NS 2000
`define BUS_RESET_CYCLES ((`BUS_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [hw/bus_reset_gap_count_control.sv]
// Bus reset sequencing and gap count control with an APB register slave.
`timescale 1ns/100ps
`include "bus_reset_consts.svh"
module bus_reset_gap_count_control
    import bus_reset_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cfg_rx_valid,
    input wire logic cfg_rx_holdoff,
    input wire logic [5:0] cfg_rx_gap,
    input wire logic cfg_tx_valid,
    input wire logic cfg_tx_holdoff,
    input wire logic [5:0] cfg_tx_gap,
    input wire logic bus_reset_seen,
    input wire logic init_done,
    output logic bus_reset_active,
    output logic bus_init_active,
    output logic root_holdoff_flag,
    output logic [5:0] gap_count
);
    // The reset length is counted in whole clock cycles, so the period
    // constant must follow any change of the clock, or the signalling would
    // run short of its minimum length.
    localparam logic [7:0] RESET_CYCLES = 8'(`BUS_RESET_CYCLES);

    // The tracker owns the hold-off flag, the gap count and the reset count;
    // this module only tells it what was loaded and when a reset began.
    gap_update_if upd ();

    gap_count_tracker u_tracker (
        .clock(clock),
        .reset_n(reset_n),
        .upd(upd)
    );

    // Register map, one aligned word each:
    //   control word: hold-off flag, start-reset trigger and gap count;
    //   status word: reset and initialisation phases and the reset count.
    // Bits above the low byte read as zero and are ignored on write.

    // APB decode: access phase is the only moment a write takes effect.
    logic setup_phase;
    logic access_phase;
    logic hit_gap;
    logic hit_status;
    logic mapped;
    logic wr_gap;
    logic start_reset_bit;

    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign hit_gap = (paddr == `REG_ADDR_RESET_GAP);
    assign hit_status = (paddr == `REG_ADDR_STATUS);
    assign mapped = hit_gap || hit_status;
    assign wr_gap = access_phase && pwrite && hit_gap;
    assign start_reset_bit = pwdata[`FLD_START_BIT];

    // Zero wait states; an unmapped address answers with an error.
    // Nothing here ever needs more than one cycle, so no ready logic is kept.
    assign pready = 1'b1;
    assign pslverr = access_phase && !mapped;

    // Update source priority: register write, then sent packet, then received.
    // A packet that loses to a write in the same cycle is dropped.
    // Every write loads both fields because they share one register with the
    // start bit; a well-behaved controller only writes with the start bit set.
    always_comb begin
        upd.load = 1'b0;
        upd.load_holdoff = upd.holdoff;
        upd.load_gap = upd.gap;
        if (wr_gap) begin
            upd.load = 1'b1;
            upd.load_holdoff = pwdata[`FLD_HOLDOFF_BIT];
            upd.load_gap = pwdata[`FLD_GAP_MSB:`FLD_GAP_LSB];
        end else if (cfg_tx_valid) begin
            upd.load = 1'b1;
            upd.load_holdoff = cfg_tx_holdoff;
            upd.load_gap = cfg_tx_gap;
        end else if (cfg_rx_valid) begin
            upd.load = 1'b1;
            upd.load_holdoff = cfg_rx_holdoff;
            upd.load_gap = cfg_rx_gap;
        end
    end

    // Bus reset start: our own start-reset write or a reset seen on the cable.
    logic start_req;

    assign start_req = (wr_gap && start_reset_bit) || bus_reset_seen;
    assign upd.reset_evt = start_req;

    // Reset and initialisation sequencer state.
    reset_state_t state_q;
    reset_state_t state_d;
    logic [7:0] timer_q;
    logic [7:0] timer_d;

    // A new start request restarts the reset signalling from any state, so a
    // reset arriving during initialisation is never lost. The price is that a
    // stream of requests closer than the reset length keeps the bus in reset.
    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        if (start_req) begin
            state_d = ST_RESET;
            timer_d = RESET_CYCLES - 8'h01;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    timer_d = 8'h00;
                end
                ST_RESET: begin
                    if (timer_q == 8'h00) begin
                        state_d = ST_INIT;
                    end else begin
                        timer_d = timer_q - 8'h01;
                    end
                end
                ST_INIT: begin
                    if (init_done) begin
                        state_d = ST_IDLE;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    timer_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            timer_q <= 8'h00;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
        end
    end

    // Status outputs come from flip-flops so they are glitch free.
    // They follow the next state, so they change on the same edge as it.
    logic reset_act_q;
    logic reset_act_d;
    logic init_act_q;
    logic init_act_d;

    always_comb begin
        reset_act_d = (state_d == ST_RESET);
        init_act_d = (state_d == ST_INIT);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reset_act_q <= 1'b0;
            init_act_q <= 1'b0;
        end else begin
            reset_act_q <= reset_act_d;
            init_act_q <= init_act_d;
        end
    end

    // The flag and the gap leave straight from the tracker's flip-flops.
    assign bus_reset_active = reset_act_q;
    assign bus_init_active = init_act_q;
    assign root_holdoff_flag = upd.holdoff;
    assign gap_count = upd.gap;

    // Read data is captured in the setup phase so that it stands registered
    // through the access phase. The start bit reads back as zero because it
    // only triggers; software reads the sequencer state in the status word.
    logic [31:0] gap_word;
    logic [31:0] status_word;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Control word: hold-off flag and gap count as the tracker holds them now,
    // which after a sent packet are already the packet's values.
    always_comb begin
        gap_word = 32'h0000_0000;
        gap_word[`FLD_HOLDOFF_BIT] = upd.holdoff;
        gap_word[`FLD_GAP_MSB:`FLD_GAP_LSB] = upd.gap;
    end

    // Status word: sequencer phase and the count of resets since the last update.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`FLD_ST_RESET_BIT] = reset_act_q;
        status_word[`FLD_ST_INIT_BIT] = init_act_q;
        status_word[`FLD_ST_CNT_MSB:`FLD_ST_CNT_LSB] = upd.reset_cnt;
    end

    // An unmapped address reads zero alongside its error response.
    always_comb begin
        rdata_d = rdata_q;
        if (setup_phase) begin
            rdata_d = 32'h0000_0000;
            if (hit_gap) begin
                rdata_d = gap_word;
            end else if (hit_status) begin
                rdata_d = status_word;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;
endmodule

// [hw/bus_reset_pkg.sv]
// Types shared by the bus reset and gap count control block.
package bus_reset_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RESET,
        ST_INIT
    } reset_state_t;

    typedef logic [5:0] gap_count_t;
    typedef logic [1:0] reset_cnt_t;
endpackage

// [hw/gap_count_tracker.sv]
// Holds the hold-off flag and gap count and applies the reset fall-back.
`timescale 1ns/100ps
`include "bus_reset_consts.svh"
module gap_count_tracker
    import bus_reset_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    gap_update_if.tracker upd
);
    logic holdoff_q;
    logic holdoff_d;
    gap_count_t gap_q;
    gap_count_t gap_d;
    reset_cnt_t cnt_q;
    reset_cnt_t cnt_d;

    // An update clears the count; a reset in the same cycle then counts as the first.
    // A reset started by our own write therefore keeps the written gap.
    always_comb begin
        holdoff_d = holdoff_q;
        gap_d = gap_q;
        cnt_d = cnt_q;
        if (upd.load) begin
            holdoff_d = upd.load_holdoff;
            gap_d = upd.load_gap;
            cnt_d = upd.reset_evt ? 2'h1 : 2'h0;
        end else if (upd.reset_evt) begin
            if (cnt_q != `RESETS_TO_FALLBACK) begin
                cnt_d = cnt_q + 2'h1;
            end
            if (cnt_q + 2'h1 >= `RESETS_TO_FALLBACK) begin
                gap_d = `GAP_MAX;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            holdoff_q <= `HOLDOFF_RESET;
            gap_q <= `GAP_RESET;
            cnt_q <= 2'h0;
        end else begin
            holdoff_q <= holdoff_d;
            gap_q <= gap_d;
            cnt_q <= cnt_d;
        end
    end

    assign upd.holdoff = holdoff_q;
    assign upd.gap = gap_q;
    assign upd.reset_cnt = cnt_q;
endmodule

// [hw/gap_update_if.sv]
// Carrier of gap count updates between the control logic and the tracker.
`timescale 1ns/100ps
interface gap_update_if;
    import bus_reset_pkg::*;
    logic load;
    logic load_holdoff;
    gap_count_t load_gap;
    logic reset_evt;
    logic holdoff;
    gap_count_t gap;
    reset_cnt_t reset_cnt;

    modport tracker (
        input load,
        input load_holdoff,
        input load_gap,
        input reset_evt,
        output holdoff,
        output gap,
        output reset_cnt
    );
    modport user (
        output load,
        output load_holdoff,
        output load_gap,
        output reset_evt,
        input holdoff,
        input gap,
        input reset_cnt
    );
endinterface

// [verification/bus_reset_gap_count_control_sva.sv]
// Assertions on the ports of the bus reset and gap count control block.
`timescale 1ns/100ps
module reset_gap_checker (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic cfg_rx_valid,
    input wire logic [5:0] cfg_rx_gap,
    input wire logic cfg_tx_valid,
    input wire logic [5:0] cfg_tx_gap,
    input wire logic bus_reset_seen,
    input wire logic bus_reset_active,
    input wire logic root_holdoff_flag,
    input wire logic [5:0] gap_count
);
    logic wr, start, upd;
    logic [1:0] cnt_q, cnt_d;
    // Own copy of the reset count, so the fall-back moment is predicted independently.
    assign wr = psel && penable && pwrite && paddr == 8'h04;
    assign start = (wr && pwdata[6]) || bus_reset_seen;
    assign upd = wr || cfg_tx_valid || cfg_rx_valid;
    always_comb begin
        cnt_d = cnt_q;
        if (upd)
            cnt_d = {1'b0, start};
        else if (start && cnt_q != 2'h2)
            cnt_d = cnt_q + 2'h1;
    end
    always_ff @(posedge clock) begin
        if (!reset_n)
            cnt_q <= 2'h0;
        else
            cnt_q <= cnt_d;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    start_begins_a: assert property (wr && pwdata[6] |=> bus_reset_active)
        else $error("Start write began no bus reset.");
    write_loads_a: assert property (wr |=> gap_count == $past(pwdata[5:0])
        && root_holdoff_flag == $past(pwdata[7]))
        else $error("Register write did not load the fields.");
    tx_loads_a: assert property (cfg_tx_valid && !wr |=> gap_count == $past(cfg_tx_gap))
        else $error("Sent packet did not load the gap.");
    rx_loads_a: assert property (cfg_rx_valid && !wr && !cfg_tx_valid
        |=> gap_count == $past(cfg_rx_gap))
        else $error("Received packet did not load the gap.");
    gap_fallback_a: assert property (start && !upd && cnt_q != 2'h0 |=> gap_count == 6'h3F)
        else $error("Gap did not fall back after two resets.");
    gap_holds_a: assert property (!upd && !(start && cnt_q != 2'h0) |=> $stable(gap_count))
        else $error("Gap changed without cause.");
endmodule

bind bus_reset_gap_count_control reset_gap_checker i_reset_gap_checker (.*);

// [verification/link_ctrl_model.sv]
// Model of the link-layer controller that reaches the control register over APB.
`timescale 1ns/100ps
module link_ctrl_model (
    input wire logic clock,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0
);
    // One transfer; the request stands until pready is sampled high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (!pready)
            @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // After a packet the fields are read back, so the reset carries the packet's values.
    task automatic reset_after_cfg();
        logic [31:0] v;
        logic e;
        xfer(1'b0, 8'h04, 32'h0, v, e);
        xfer(1'b1, 8'h04, {24'h0, v[7], 1'b1, v[5:0]}, v, e);
    endtask
    // Any other reset asks for gap 63 and keeps the present hold-off value.
    task automatic plain_reset();
        logic [31:0] v;
        logic e;
        xfer(1'b0, 8'h04, 32'h0, v, e);
        xfer(1'b1, 8'h04, {24'h0, v[7], 1'b1, 6'h3F}, v, e);
    endtask
endmodule

// [verification/tb.sv]
// Self-checking bench for the bus reset and gap count control block.
`timescale 1ns/100ps
`include "bus_reset_consts.svh"
module tb;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic cfg_rx_valid = 1'b0, cfg_rx_holdoff = 1'b0, cfg_tx_valid = 1'b0, cfg_tx_holdoff = 1'b0;
    logic [5:0] cfg_rx_gap = 6'h00, cfg_tx_gap = 6'h00, gap_count;
    logic bus_reset_seen = 1'b0, init_done = 1'b0;
    logic bus_reset_active, bus_init_active, root_holdoff_flag;
    int fails = 0, n_tests = 0;
    bus_reset_gap_count_control i_bus_reset_gap_count_control (.*);
    link_ctrl_model i_link_ctrl_model (.*);
    // Free-running 50 MHz clock.
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        i_link_ctrl_model.xfer(1'b0, a, 32'h0, rd, err);
        chk(rd, exp);
        chk(err, eexp);
    endtask
    // One-cycle packet pulse, sent or received.
    task automatic pkt(input logic tx, input logic h, input logic [5:0] g);
        @(posedge clock);
        cfg_tx_valid <= tx;
        cfg_rx_valid <= !tx;
        cfg_tx_holdoff <= h;
        cfg_rx_holdoff <= h;
        cfg_tx_gap <= g;
        cfg_rx_gap <= g;
        @(posedge clock);
        cfg_tx_valid <= 1'b0;
        cfg_rx_valid <= 1'b0;
    endtask
    // A cable reset when seen is set, otherwise the one already running, then the initialisation is let finish.
    // The reset signalling is measured against its fixed cycle count on the way.
    task automatic finish_init(input logic seen);
        int n = 0;
        if (seen) begin
            @(posedge clock);
            bus_reset_seen <= 1'b1;
            @(posedge clock);
            bus_reset_seen <= 1'b0;
        end
        for (int i = 0; i < 200 && bus_init_active !== 1'b1; i++) begin
            @(posedge clock);
            if (bus_reset_active === 1'b1) begin
                n++;
            end
        end
        chk(bus_init_active, 1'b1);
        chk(n, `BUS_RESET_CYCLES);
        init_done <= 1'b1;
        @(posedge clock);
        init_done <= 1'b0;
        @(posedge clock);
        chk(bus_init_active, 1'b0);
    endtask
    task automatic t_cfg_reset();
        pkt(1'b1, 1'b1, 6'h05);
        rd_reg(8'h04, 32'h85, 1'b0);
        i_link_ctrl_model.reset_after_cfg();
        #1;
        chk(bus_reset_active, 1'b1);
        finish_init(1'b0);
        rd_reg(8'h04, 32'h85, 1'b0);
    endtask
    task automatic t_plain();
        pkt(1'b0, 1'b0, 6'h14);
        rd_reg(8'h04, 32'h14, 1'b0);
        i_link_ctrl_model.plain_reset();
        #1;
        chk({root_holdoff_flag, gap_count}, 7'h3F);
        finish_init(1'b0);
    endtask
    task automatic t_fallback();
        pkt(1'b0, 1'b1, 6'h09);
        finish_init(1'b1);
        rd_reg(8'h04, 32'h89, 1'b0);
        finish_init(1'b1);
        rd_reg(8'h04, 32'hBF, 1'b0);
        rd_reg(8'h08, 32'h08, 1'b0);
        pkt(1'b1, 1'b0, 6'h07);
        finish_init(1'b1);
        rd_reg(8'h04, 32'h07, 1'b0);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        rd_reg(8'h04, 32'h3F, 1'b0);
        t_cfg_reset();
        t_plain();
        t_fallback();
        rd_reg(8'h0C, 32'h0, 1'b1);
        end_of_test();
    end
    // A hang is cut short well beyond the few resets the run needs.
    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        end_of_test();
    end
endmodule
